// *** core/dual_uart.sv ***
`timescale 1ns/100ps
// Summary of operation
// - Mode 0: receive ready low when data present
// - Mode 1: receive ready high when empty or untriggered
// - Mode 0: transmit ready low only when empty
// - Mode 1: transmit ready high when full
// - Ready pins pace DMA modes 0/1
// - Serial output idles high
// - Loopback: output off unless break set, stream fed back
// - Chip select and channel bit pick channel
// - Start bit, data, stop bits framing
// - Optional parity sent and checked
// - Sixteen-byte transmit and receive FIFOs
// - Four selectable receive trigger levels
// - Strobe low writes, high reads register
// - Active-low reset clears everything
// - Channel interrupts merged, open-drain, low
module dual_uart (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       reset_n,
  input  wire logic       cs_n,
  input  wire logic       channel_addr_bit,
  input  wire logic [2:0] addr,
  input  wire logic       rw,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic       serial_in_a,
  input  wire logic       serial_in_b,
  output logic            serial_out_a,
  output logic            serial_out_b,
  output logic            rx_ready_out_a,
  output logic            rx_ready_out_b,
  output logic            tx_ready_out_a,
  output logic            tx_ready_out_b,
  output logic            irq_out,
  output logic            irq_oe
);
  import dual_uart_pkg::*;

  // Per-channel state
  typedef struct packed {
    logic [15:0][7:0] txm;     // Transmit FIFO storage
    logic [15:0][7:0] rxm;     // Receive FIFO storage
    logic [3:0]       txw;     // Transmit write pointer
    logic [3:0]       txr;     // Transmit read pointer
    logic [4:0]       txc;     // Transmit fill count
    logic [3:0]       rxw;     // Receive write pointer
    logic [3:0]       rxr;     // Receive read pointer
    logic [4:0]       rxc;     // Receive fill count
    logic [3:0]       ier;     // Interrupt enables
    logic [7:0]       lcr;     // Line control
    logic [4:0]       mcr;     // Modem control
    logic [7:0]       fcr;     // FIFO control copy
    logic [7:0]       spr;     // Scratchpad
    logic [15:0]      div;     // Baud divisor
    logic [15:0]      bcnt;    // Baud counter
    logic             oe;      // Overrun error
    logic             pe;      // Parity error
    logic             fe;      // Framing error
    ser_st_t          tst;     // Transmitter state
    logic [3:0]       ttk;     // Transmit tick count
    logic [2:0]       tbit;    // Transmit bit index
    logic [7:0]       tsh;     // Transmit shifter
    logic             tpar;    // Transmit parity bit
    logic             sout;    // Serial stream before gating
    ser_st_t          rst_st;  // Receiver state
    logic [3:0]       rtk;     // Receive tick count
    logic [2:0]       rbit;    // Receive bit index
    logic [7:0]       rsh;     // Receive shifter
    logic             rpar;    // Received parity bit
    logic             line;    // Pin level
    logic             rxr_n;   // Receive ready pin
    logic             txr_n;   // Transmit ready pin
  } ch_t;

  typedef struct packed {
    ch_t [1:0]  ch;
    logic [7:0] dout;  // Read data
    logic       doe;   // Data bus drive
    logic       irq;   // Interrupt drive
    logic       cs_d;  // Previous chip select
  } top_t;

  // Reset image
  function automatic top_t init_st();
    top_t t;
    t      = '0;
    t.cs_d = 1'b1;
    for (int c = 0; c < 2; c++) begin
      t.ch[c].div   = DIV_RESET;
      t.ch[c].bcnt  = DIV_RESET;
      t.ch[c].sout  = 1'b1;
      t.ch[c].line  = 1'b1;
      t.ch[c].rxr_n = 1'b1;
    end
    return t;
  endfunction

  localparam top_t ST_RST = init_st();

  top_t s_r;    // Registered state
  top_t s_nxt;  // Next state

  logic [1:0] sin_pin;  // Serial inputs as array
  logic [1:0] sk_iv;    // Character complete
  logic [1:0] sk_ir;    // Buffer has room
  logic [1:0] sk_ov;    // Buffer holds a byte
  logic [1:0] sk_or;    // Receive FIFO has room
  logic [1:0] sk_clr;   // Flush buffer
  logic [7:0] sk_id [2];
  logic [7:0] sk_od [2];

  assign sin_pin = {serial_in_b, serial_in_a};

  // Two-entry buffer between deserialiser and receive FIFO
  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign sk_or[g] = (s_r.ch[g].rxc < (s_r.ch[g].fcr[FCR_EN] ? FIFO_DEPTH : 5'h01));
    rx_skid_buffer #(.WIDTH(8)) i_rx_skid_buffer (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clr      (sk_clr[g]),
      .in_valid (sk_iv[g]),
      .in_data  (sk_id[g]),
      .in_ready (sk_ir[g]),
      .out_valid(sk_ov[g]),
      .out_data (sk_od[g]),
      .out_ready(sk_or[g])
    );
  end

  // Bus access, serial engines, FIFOs and ready pins
  always_comb begin
    logic       acc, sel, wr, rd, dlab, tick, sin, pen, even;
    logic [4:0] cap, trig;
    logic [2:0] nb;
    logic [7:0] mask, rdat;
    logic [3:0] isr;
    acc = 1'b0; sel = 1'b0; wr = 1'b0; rd = 1'b0; dlab = 1'b0; tick = 1'b0;
    sin = 1'b1; pen = 1'b0; even = 1'b0; cap = '0; trig = '0; nb = '0;
    mask = '0; rdat = '0; isr = '0;
    s_nxt      = s_r;
    sk_iv      = '0;
    sk_clr     = '0;
    sk_id[0]   = '0;
    sk_id[1]   = '0;
    s_nxt.irq  = 1'b0;
    s_nxt.cs_d = cs_n;
    s_nxt.doe  = ~cs_n & rw;
    // Access taken on the falling edge of chip select
    acc = s_r.cs_d & ~cs_n;
    for (int c = 0; c < 2; c++) begin
      dlab = s_r.ch[c].lcr[LCR_DLAB];
      pen  = s_r.ch[c].lcr[LCR_PEN];
      even = s_r.ch[c].lcr[LCR_EVEN];
      nb   = {1'b0, s_r.ch[c].lcr[1:0]} + 3'h4;
      mask = 8'hff >> (2'h3 - s_r.ch[c].lcr[1:0]);
      cap  = s_r.ch[c].fcr[FCR_EN] ? FIFO_DEPTH : 5'h01;
      unique case (s_r.ch[c].fcr[7:6])
        2'h0: trig = TRIG_L0;
        2'h1: trig = TRIG_L1;
        2'h2: trig = TRIG_L2;
        2'h3: trig = TRIG_L3;
      endcase
      if (!s_r.ch[c].fcr[FCR_EN]) begin
        trig = TRIG_L0;
      end
      sel = acc & (channel_addr_bit == 1'(c));
      wr  = sel & ~rw;
      rd  = sel & rw;
      // Status code, highest priority first
      if (s_r.ch[c].ier[IER_LS] && (s_r.ch[c].oe || s_r.ch[c].pe || s_r.ch[c].fe)) begin
        isr = ISR_LS;
      end else if (s_r.ch[c].ier[IER_RX] && s_r.ch[c].rxc >= trig) begin
        isr = ISR_RX;
      end else if (s_r.ch[c].ier[IER_TX] && s_r.ch[c].txc == 5'h00) begin
        isr = ISR_TX;
      end else begin
        isr = ISR_NONE;
      end
      // Register writes
      if (wr) begin
        unique case (addr)
          OFF_DATA: begin
            if (dlab) begin
              s_nxt.ch[c].div[7:0] = data_in;
            end else if (s_r.ch[c].txc < cap) begin
              s_nxt.ch[c].txm[s_r.ch[c].txw] = data_in;
              s_nxt.ch[c].txw = s_r.ch[c].txw + 4'h1;
              s_nxt.ch[c].txc = s_r.ch[c].txc + 5'h01;
            end
          end
          OFF_IER: begin
            if (dlab) begin
              s_nxt.ch[c].div[15:8] = data_in;
            end else begin
              s_nxt.ch[c].ier = data_in[3:0];
            end
          end
          OFF_FCR: begin
            s_nxt.ch[c].fcr = data_in;
            if (data_in[FCR_RXC]) begin
              s_nxt.ch[c].rxc = '0;
              s_nxt.ch[c].rxw = '0;
              s_nxt.ch[c].rxr = '0;
              sk_clr[c]       = 1'b1;
            end
            if (data_in[FCR_TXC]) begin
              s_nxt.ch[c].txc = '0;
              s_nxt.ch[c].txw = '0;
              s_nxt.ch[c].txr = '0;
            end
          end
          OFF_LCR: s_nxt.ch[c].lcr = data_in;
          OFF_MCR: s_nxt.ch[c].mcr = data_in[4:0];
          OFF_SPR: s_nxt.ch[c].spr = data_in;
          default: ;
        endcase
      end
      // Register reads; data reads pop, line status reads clear errors
      if (rd) begin
        unique case (addr)
          OFF_DATA: begin
            rdat = dlab ? s_r.ch[c].div[7:0] : s_r.ch[c].rxm[s_r.ch[c].rxr];
            if (!dlab && s_r.ch[c].rxc != 5'h00) begin
              s_nxt.ch[c].rxr = s_r.ch[c].rxr + 4'h1;
              s_nxt.ch[c].rxc = s_nxt.ch[c].rxc - 5'h01;
            end
          end
          OFF_IER: rdat = dlab ? s_r.ch[c].div[15:8] : {4'h0, s_r.ch[c].ier};
          OFF_FCR: rdat = {{2{s_r.ch[c].fcr[FCR_EN]}}, 2'h0, isr};
          OFF_LCR: rdat = s_r.ch[c].lcr;
          OFF_MCR: rdat = {3'h0, s_r.ch[c].mcr};
          OFF_LSR: begin
            rdat = {1'b0, (s_r.ch[c].txc == 5'h00) && (s_r.ch[c].tst == s_idle),
                    s_r.ch[c].txc == 5'h00, 1'b0, s_r.ch[c].fe, s_r.ch[c].pe,
                    s_r.ch[c].oe, s_r.ch[c].rxc != 5'h00};
            s_nxt.ch[c].oe = 1'b0;
            s_nxt.ch[c].pe = 1'b0;
            s_nxt.ch[c].fe = 1'b0;
          end
          OFF_MSR: rdat = 8'h00;
          OFF_SPR: rdat = s_r.ch[c].spr;
        endcase
        s_nxt.dout = rdat;
      end
      // Baud tick, sixteen per bit
      if (s_r.ch[c].bcnt <= 16'h0001) begin
        s_nxt.ch[c].bcnt = (s_r.ch[c].div == 16'h0000) ? DIV_RESET : s_r.ch[c].div;
        tick = 1'b1;
      end else begin
        s_nxt.ch[c].bcnt = s_r.ch[c].bcnt - 16'h0001;
        tick = 1'b0;
      end
      // receiver fed from own stream in loopback
      sin = s_r.ch[c].mcr[MCR_LOOP] ? s_r.ch[c].sout : sin_pin[c];
      // Transmitter
      if (tick) begin
        s_nxt.ch[c].ttk = s_r.ch[c].ttk + 4'h1;
        unique case (s_r.ch[c].tst)
          s_idle: begin
            s_nxt.ch[c].ttk = '0;
            if (s_nxt.ch[c].txc != 5'h00) begin
              // start bit first
              // Next-state copy so a byte written this cycle is sent, not a stale slot
              s_nxt.ch[c].tsh  = s_nxt.ch[c].txm[s_r.ch[c].txr] & mask;
              s_nxt.ch[c].tpar = ^(s_nxt.ch[c].txm[s_r.ch[c].txr] & mask) ^ ~even;
              s_nxt.ch[c].txr  = s_r.ch[c].txr + 4'h1;
              s_nxt.ch[c].txc  = s_nxt.ch[c].txc - 5'h01;
              s_nxt.ch[c].sout = 1'b0;
              s_nxt.ch[c].tst  = s_start;
            end
          end
          s_start: if (s_r.ch[c].ttk == TICK_LAST) begin
            s_nxt.ch[c].sout = s_r.ch[c].tsh[0];
            s_nxt.ch[c].tbit = '0;
            s_nxt.ch[c].tst  = s_data;
          end
          s_data: if (s_r.ch[c].ttk == TICK_LAST) begin
            s_nxt.ch[c].tsh  = s_r.ch[c].tsh >> 1;
            s_nxt.ch[c].tbit = s_r.ch[c].tbit + 3'h1;
            s_nxt.ch[c].sout = s_r.ch[c].tsh[1];
            if (s_r.ch[c].tbit == nb) begin
              s_nxt.ch[c].tbit = '0;
              s_nxt.ch[c].sout = pen ? s_r.ch[c].tpar : 1'b1;
              s_nxt.ch[c].tst  = pen ? s_par : s_stop;
            end
          end
          s_par: if (s_r.ch[c].ttk == TICK_LAST) begin
            s_nxt.ch[c].sout = 1'b1;
            s_nxt.ch[c].tst  = s_stop;
          end
          s_stop: if (s_r.ch[c].ttk == TICK_LAST) begin
            s_nxt.ch[c].tbit = s_r.ch[c].tbit + 3'h1;
            if (s_r.ch[c].tbit == {2'h0, s_r.ch[c].lcr[LCR_STOP]}) begin
              s_nxt.ch[c].tst = s_idle;
            end
          end
          default: s_nxt.ch[c].tst = s_idle;
        endcase
      end
      // Receiver
      if (tick) begin
        s_nxt.ch[c].rtk = s_r.ch[c].rtk + 4'h1;
        unique case (s_r.ch[c].rst_st)
          s_idle: begin
            s_nxt.ch[c].rtk = '0;
            if (!sin) begin
              s_nxt.ch[c].rst_st = s_start;
            end
          end
          s_start: if (s_r.ch[c].rtk == TICK_MID) begin
            s_nxt.ch[c].rtk    = '0;
            s_nxt.ch[c].rbit   = '0;
            s_nxt.ch[c].rst_st = sin ? s_idle : s_data;
          end
          s_data: if (s_r.ch[c].rtk == TICK_LAST) begin
            s_nxt.ch[c].rsh  = {sin, s_r.ch[c].rsh[7:1]};
            s_nxt.ch[c].rbit = s_r.ch[c].rbit + 3'h1;
            if (s_r.ch[c].rbit == nb) begin
              s_nxt.ch[c].rst_st = pen ? s_par : s_stop;
            end
          end
          s_par: if (s_r.ch[c].rtk == TICK_LAST) begin
            s_nxt.ch[c].rpar   = sin;
            s_nxt.ch[c].rst_st = s_stop;
          end
          s_stop: if (s_r.ch[c].rtk == TICK_LAST) begin
            sk_iv[c] = 1'b1;
            sk_id[c] = s_r.ch[c].rsh >> (2'h3 - s_r.ch[c].lcr[1:0]);
            // parity check; errors win over a same-cycle clear
            if (pen && (s_r.ch[c].rpar != (^sk_id[c] ^ ~even))) begin
              s_nxt.ch[c].pe = 1'b1;
            end
            if (!sin) begin
              s_nxt.ch[c].fe = 1'b1;
            end
            if (!sk_ir[c]) begin
              s_nxt.ch[c].oe = 1'b1;
            end
            s_nxt.ch[c].rst_st = s_idle;
          end
          default: s_nxt.ch[c].rst_st = s_idle;
        endcase
      end
      if (sk_ov[c] && sk_or[c]) begin
        s_nxt.ch[c].rxm[s_r.ch[c].rxw] = sk_od[c];
        s_nxt.ch[c].rxw = s_r.ch[c].rxw + 4'h1;
        s_nxt.ch[c].rxc = s_nxt.ch[c].rxc + 5'h01;
      end
      // line low on break, else high when idle, off in loopback
      s_nxt.ch[c].line = s_nxt.ch[c].lcr[LCR_BRK] ? 1'b0 :
                         (s_nxt.ch[c].mcr[MCR_LOOP] ? 1'b1 : s_nxt.ch[c].sout);
      if (s_nxt.ch[c].fcr[FCR_EN] && s_nxt.ch[c].fcr[FCR_DMA]) begin
        s_nxt.ch[c].rxr_n = (s_nxt.ch[c].rxc < trig);
        s_nxt.ch[c].txr_n = (s_nxt.ch[c].txc >= cap);
      end else begin
        s_nxt.ch[c].rxr_n = (s_nxt.ch[c].rxc == 5'h00);
        s_nxt.ch[c].txr_n = (s_nxt.ch[c].txc != 5'h00);
      end
      if (isr != ISR_NONE) begin
        s_nxt.irq = 1'b1;
      end
    end
    if (!reset_n) begin
      s_nxt  = ST_RST;
      sk_clr = '1;  // Buffered bytes must not reach the FIFO after reset
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state, interrupt pin value tied low
  assign data_out       = s_r.dout;
  assign data_oe        = s_r.doe;
  assign serial_out_a   = s_r.ch[0].line;
  assign serial_out_b   = s_r.ch[1].line;
  assign rx_ready_out_a = s_r.ch[0].rxr_n;
  assign rx_ready_out_b = s_r.ch[1].rxr_n;
  assign tx_ready_out_a = s_r.ch[0].txr_n;
  assign tx_ready_out_b = s_r.ch[1].txr_n;
  assign irq_out        = 1'b0;
  assign irq_oe         = s_r.irq;

endmodule

// *** core/dual_uart_pkg.sv ***
package dual_uart_pkg;

  // Register offsets on the three low address bits
  localparam logic [2:0] OFF_DATA = 3'h0;  // Receive/transmit holding, divisor low
  localparam logic [2:0] OFF_IER  = 3'h1;  // Interrupt enable, divisor high
  localparam logic [2:0] OFF_FCR  = 3'h2;  // Status read, FIFO control write
  localparam logic [2:0] OFF_LCR  = 3'h3;  // Line control
  localparam logic [2:0] OFF_MCR  = 3'h4;  // Modem control
  localparam logic [2:0] OFF_LSR  = 3'h5;  // Line status
  localparam logic [2:0] OFF_MSR  = 3'h6;  // Modem status
  localparam logic [2:0] OFF_SPR  = 3'h7;  // Scratchpad

  // Field positions
  localparam int LCR_STOP = 2;   // Two stop bits
  localparam int LCR_PEN  = 3;   // Parity enable
  localparam int LCR_EVEN = 4;   // Even parity
  localparam int LCR_BRK  = 6;   // Force line low
  localparam int LCR_DLAB = 7;   // Divisor access
  localparam int MCR_LOOP = 4;   // Local loopback
  localparam int FCR_EN   = 0;   // FIFO enable
  localparam int FCR_RXC  = 1;   // Flush receive FIFO
  localparam int FCR_TXC  = 2;   // Flush transmit FIFO
  localparam int FCR_DMA  = 3;   // DMA mode 1
  localparam int IER_RX   = 0;   // Receive data interrupt
  localparam int IER_TX   = 1;   // Transmit empty interrupt
  localparam int IER_LS   = 2;   // Line status interrupt

  // Sizes, reset values and timing counts
  localparam logic [4:0]  FIFO_DEPTH = 5'h10;  // Sixteen bytes each way
  localparam logic [3:0]  TICK_LAST  = 4'hf;   // Sixteen ticks per bit
  localparam logic [3:0]  TICK_MID   = 4'h7;   // Mid-bit of the start bit
  localparam logic [15:0] DIV_RESET  = 16'h0001;
  localparam logic [4:0]  TRIG_L0    = 5'h01;
  localparam logic [4:0]  TRIG_L1    = 5'h04;
  localparam logic [4:0]  TRIG_L2    = 5'h08;
  localparam logic [4:0]  TRIG_L3    = 5'h0e;

  // Status codes
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_LS   = 4'h6;
  localparam logic [3:0] ISR_RX   = 4'h4;
  localparam logic [3:0] ISR_TX   = 4'h2;

  // Serial engine states, shared by transmitter and receiver
  typedef enum logic [2:0] {
    s_idle  = 3'b000,
    s_start = 3'b001,
    s_data  = 3'b010,
    s_par   = 3'b011,
    s_stop  = 3'b100
  } ser_st_t;

endpackage

// *** core/rx_skid_buffer.sv ***
`timescale 1ns/100ps
module rx_skid_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clr,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  // Two slots plus occupancy
  typedef struct packed {
    logic [1:0][WIDTH-1:0] d;
    logic [1:0]            cnt;
  } skid_t;

  skid_t s_r;   // Registered state
  skid_t s_nxt; // Next state

  assign in_ready  = (s_r.cnt != 2'h2);
  assign out_valid = (s_r.cnt != 2'h0);
  assign out_data  = s_r.d[0];

  // Pop from the head, then push behind what remains
  always_comb begin
    s_nxt = s_r;
    if (out_valid && out_ready) begin
      s_nxt.d[0] = s_nxt.d[1];
      s_nxt.cnt  = s_nxt.cnt - 2'h1;
    end
    if (in_valid && in_ready) begin
      s_nxt.d[s_nxt.cnt[0]] = in_data;
      s_nxt.cnt             = s_nxt.cnt + 2'h1;
    end
    // Flush drops both slots
    if (clr) begin
      s_nxt = '0;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// *** dv/dual_uart_sva.sv ***
`timescale 1ns/100ps
module dual_uart_sva (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       reset_n,
  input wire logic       cs_n,
  input wire logic       channel_addr_bit,
  input wire logic [2:0] addr,
  input wire logic       rw,
  input wire logic [7:0] data_in,
  input wire logic       data_oe,
  input wire logic       serial_out_a,
  input wire logic       serial_out_b,
  input wire logic       rx_ready_out_a,
  input wire logic       rx_ready_out_b,
  input wire logic       tx_ready_out_a,
  input wire logic       tx_ready_out_b,
  input wire logic       irq_out,
  input wire logic       irq_oe
);
  logic cs_prev_r;  // Select level one edge ago
  logic loop_a_r;   // Shadow of the channel A loopback bit
  logic take_a;     // Access taken on channel A

  assign take_a = !cs_n && cs_prev_r && !channel_addr_bit;

  // Track access edges and loopback writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_prev_r <= 1'b1;
      loop_a_r  <= 1'b0;
    end else if (!reset_n) begin
      cs_prev_r <= cs_n;
      loop_a_r  <= 1'b0;
    end else begin
      cs_prev_r <= cs_n;
      if (take_a && !rw && addr == 3'h4) begin
        loop_a_r <= data_in[4];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_OE_SET: assert property ((!cs_n && rw && reset_n) |=> data_oe)
    else $error("data bus not driven during a read");
  AST_OE_CAUSE: assert property (data_oe |-> $past(!cs_n && rw))
    else $error("data bus driven without a selected read");
  AST_IRQ_PIN: assert property (!irq_out)
    else $error("interrupt pin value not low");
  AST_RST_OUT: assert property (!reset_n |=> (serial_out_a && serial_out_b && rx_ready_out_a
    && rx_ready_out_b && !tx_ready_out_a && !tx_ready_out_b && !irq_oe && !data_oe))
    else $error("outputs not at reset state");
  AST_LOOP_A: assert property ((loop_a_r && $past(loop_a_r)) |-> serial_out_a)
    else $error("serial output active during loopback");
  AST_START_B: assert property (disable iff (rst || !reset_n) $fell(serial_out_b) |=> (!serial_out_b)[*7])
    else $error("start bit too short");
  AST_TX_RISE: assert property ($rose(tx_ready_out_a) |-> $past(take_a && !rw))
    else $error("transmit ready rose without a write");
  AST_RX_RISE: assert property ($rose(rx_ready_out_a) |-> $past(take_a || !reset_n))
    else $error("receive ready rose without an access");
endmodule

bind dual_uart dual_uart_sva i_dual_uart_sva (.clk_sys(clk_sys), .rst(rst), .reset_n(reset_n), .cs_n(cs_n),
  .channel_addr_bit(channel_addr_bit), .addr(addr), .rw(rw), .data_in(data_in), .data_oe(data_oe),
  .serial_out_a(serial_out_a), .serial_out_b(serial_out_b), .rx_ready_out_a(rx_ready_out_a),
  .rx_ready_out_b(rx_ready_out_b), .tx_ready_out_a(tx_ready_out_a), .tx_ready_out_b(tx_ready_out_b),
  .irq_out(irq_out), .irq_oe(irq_oe));

// *** dv/host_bus_model.sv ***
`timescale 1ns/100ps
module host_bus_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            cs_n,
  output logic            channel_addr_bit,
  output logic      [2:0] addr,
  output logic            rw,
  output logic      [7:0] data_in
);
  // Bus idle at time zero
  initial begin
    cs_n = 1'b1;
    channel_addr_bit = 1'b0;
    addr = 3'h0;
    rw = 1'b1;
    data_in = 8'h00;
  end

  task automatic access(input logic ch, input logic [2:0] a, input logic wr, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    cs_n = 1'b0;
    channel_addr_bit = ch;
    addr = a;
    rw = !wr;
    data_in = d;
    repeat (2) @(posedge clk_sys);
    // Bus floats unless the device drives it
    q = data_oe ? data_out : 8'hxx;
    #1;
    cs_n = 1'b1;
    rw = 1'b1;
    data_in = ~d;
  endtask
endmodule

// *** dv/tb_dual_uart_channel_ready_status.sv ***
`timescale 1ns/100ps
module tb_dual_uart_channel_ready_status;
  import dual_uart_pkg::*;
  logic       clk_sys, rst, reset_n, serial_in_a;           // Clock, resets, line into A
  logic       cs_n, channel_addr_bit, rw, data_oe;          // Host bus controls
  logic [2:0] addr;                                         // Register offset
  logic [7:0] data_in, data_out;                            // Bus data both ways
  logic       serial_out_a, serial_out_b;                   // Serial outputs, B looped back
  logic       rx_ready_out_a, rx_ready_out_b, tx_ready_out_a, tx_ready_out_b, irq_out, irq_oe;
  int         num_errors;                                   // Mismatches seen
  int         compares;                                     // Comparisons made

  dual_uart i_dual_uart (.clk_sys(clk_sys), .rst(rst), .reset_n(reset_n), .cs_n(cs_n),
    .channel_addr_bit(channel_addr_bit), .addr(addr), .rw(rw), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .serial_in_a(serial_in_a), .serial_in_b(serial_out_b), .serial_out_a(serial_out_a),
    .serial_out_b(serial_out_b), .rx_ready_out_a(rx_ready_out_a), .rx_ready_out_b(rx_ready_out_b),
    .tx_ready_out_a(tx_ready_out_a), .tx_ready_out_b(tx_ready_out_b), .irq_out(irq_out), .irq_oe(irq_oe));
  host_bus_model i_host_bus_model (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n),
    .channel_addr_bit(channel_addr_bit), .addr(addr), .rw(rw), .data_in(data_in));

  // Clock at 25 MHz
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host_bus_model.access(ch, a, 1'b1, d, q);
  endtask

  task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] q);
    i_host_bus_model.access(ch, a, 1'b0, 8'h00, q);
  endtask

  // Scratch registers of the two channels stay apart
  task automatic t_select();
    logic [7:0] q;
    wr(1'b0, OFF_SPR, 8'h5a);
    wr(1'b1, OFF_SPR, 8'hc3);
    rd(1'b0, OFF_SPR, q);
    check(q, 8'h5a);
    rd(1'b1, OFF_SPR, q);
    check(q, 8'hc3);
  endtask

  // One even-parity frame on B, received back through the external loop
  task automatic t_frame();
    logic [10:0] seen;
    logic [7:0]  q;
    int          n;
    wr(1'b1, OFF_LCR, 8'h1b);
    wr(1'b1, OFF_DATA, 8'h07);
    n = 0;
    while (serial_out_b === 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      seen[i] = serial_out_b;
      repeat (16) @(posedge clk_sys);
    end
    check(seen[8:1], 8'h07);
    check({5'h0, seen[10:9], seen[0]}, 8'h06);
    check(serial_out_b, 1'b1);
    rd(1'b1, OFF_LSR, q);
    check({q[2], q[0]}, 8'h01);
    rd(1'b1, OFF_DATA, q);
    check(q, 8'h07);
  endtask

  // Short low glitch is not taken as a character
  task automatic t_false_start();
    logic [7:0] q;
    @(posedge clk_sys);
    #1;
    serial_in_a = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    serial_in_a = 1'b1;
    repeat (300) @(posedge clk_sys);
    rd(1'b0, OFF_LSR, q);
    check(q[0], 1'b0);
    check(rx_ready_out_a, 1'b1);
  endtask

  // Each receive trigger level in block mode, through loopback on A
  task automatic t_levels();
    logic [4:0] trig [4];
    logic [7:0] q;
    trig = '{TRIG_L0, TRIG_L1, TRIG_L2, TRIG_L3};
    wr(1'b0, OFF_MCR, 8'h10);
    wr(1'b0, OFF_LCR, 8'h03);
    for (int k = 0; k < 4; k++) begin
      wr(1'b0, OFF_FCR, {k[1:0], 6'h0f});
      for (int j = 0; j < trig[k] - 1; j++) begin
        wr(1'b0, OFF_DATA, 8'h30 + j[7:0]);
      end
      repeat (trig[k] * 160 + 100) @(posedge clk_sys);
      check(rx_ready_out_a, 1'b1);
      wr(1'b0, OFF_DATA, 8'h2f + trig[k]);
      // Start bit of the looped frame is under way here
      check(serial_out_a, 1'b1);
      repeat (260) @(posedge clk_sys);
      check(rx_ready_out_a, 1'b0);
      rd(1'b0, OFF_DATA, q);
      check(q, (trig[k] == 5'h01) ? 8'h30 : 8'h30);
    end
  endtask

  // Transmit ready in block mode until full, then in single mode
  task automatic t_tx_ready();
    int n;
    wr(1'b0, OFF_LCR, 8'h83);
    wr(1'b0, OFF_DATA, 8'hff);
    wr(1'b0, OFF_IER, 8'hff);
    wr(1'b0, OFF_LCR, 8'h03);
    wr(1'b0, OFF_FCR, 8'h0f);
    check(tx_ready_out_a, 1'b0);
    n = 0;
    while (tx_ready_out_a === 1'b0 && n < 20) begin
      wr(1'b0, OFF_DATA, n[7:0]);
      n++;
    end
    check({3'h0, n[4:0]}, {3'h0, FIFO_DEPTH});
    wr(1'b0, OFF_FCR, 8'h07);
    check(tx_ready_out_a, 1'b0);
    wr(1'b0, OFF_DATA, 8'h41);
    check(tx_ready_out_a, 1'b1);
    wr(1'b0, OFF_FCR, 8'h07);
    wr(1'b0, OFF_IER, 8'h02);
    check(irq_oe, 1'b1);
    wr(1'b0, OFF_IER, 8'h00);
    check(irq_oe, 1'b0);
  endtask

  // Device reset pin clears registers and pins
  task automatic t_reset();
    logic [7:0] q;
    @(posedge clk_sys);
    #1;
    reset_n = 1'b0;
    @(posedge clk_sys);
    #1;
    check({serial_out_a, serial_out_b, rx_ready_out_a, rx_ready_out_b, tx_ready_out_a, tx_ready_out_b,
           irq_oe, data_oe}, 8'hf0);
    reset_n = 1'b1;
    rd(1'b0, OFF_SPR, q);
    check(q, 8'h00);
  endtask

  // Counts and verdict
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    num_errors = 0;
    compares = 0;
    rst = 1'b1;
    reset_n = 1'b1;
    serial_in_a = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_select();
    t_frame();
    t_false_start();
    t_levels();
    t_tx_ready();
    t_reset();
    report_and_stop();
  end
endmodule
